// ---- design/codec_serial_audio_port.v ----
// Serial audio port of a voice codec: framing, bit clocking, sample shifting
//
// What this block does
// - One data bit moves each direction per bit clock period.
// - Frame sync marks each sample word; its rate is the sampling rate.
// - Received serial data goes to DAC side; ADC samples go out serially.
// - One bit clock and one frame sync time both directions.
// - Short single-cycle or long frame sync, chosen by configuration.
// - Two slots per frame; configuration picks transmit and receive slot.
// - Input data changes on rising edge; codec samples it on falling edge.
// - Codec updates output data on rising edge; partner captures on falling.
// - Every frame sync rising edge starts a new frame both directions.
// - Optimised long frame is 17 periods; slot one shrinks, data in slot two.
// - The 17-period frame is accepted only in slave operation.
// - As master, frame rate is master clock over 256 times divider 1, 2 or 4; as slave the partner's sync sets it.
// - As master, codec drives bit clock at 32x frame rate, long sync only.
// - After reset the port is slave with short frame sync.
// - Slot one is periods 0 to 15, slot two periods 16 to 31.
`timescale 1ns/1ns
`default_nettype none
`include "codec_serial_audio_port_defines.vh"

module codec_serial_audio_port #(
    parameter SAMPLE_W = `SAP_SAMPLE_W
) (
    input  wire                clk,
    input  wire                rst,
    input  wire                cfg_load,
    input  wire                cfg_master,
    input  wire                cfg_long_sync,
    input  wire                cfg_opt_frame,
    input  wire                cfg_tx_slot,
    input  wire                cfg_rx_slot,
    input  wire [1:0]          cfg_div_sel,
    input  wire                bit_clk_in,
    output reg                 bit_clk_out,
    output reg                 bit_clk_oe,
    input  wire                frame_sync_in,
    output reg                 frame_sync_out,
    output reg                 frame_sync_oe,
    input  wire                serial_in_line,
    output reg                 serial_out_line,
    input  wire [SAMPLE_W-1:0] adc_sample,
    output reg                 adc_taken,
    output reg  [SAMPLE_W-1:0] dac_sample,
    output reg                 dac_valid,
    output reg                 frame_start,
    output reg                 master_active,
    output reg                 long_sync_format,
    output reg                 short_sync_format
);

    // ************************************************************
    // Configuration
    // ************************************************************
    reg       master_q;
    reg       long_q;
    reg       opt_q;
    reg       tx_slot_q;
    reg       rx_slot_q;
    reg [1:0] div_q;

    always @(posedge clk) begin
        if (rst) begin
            master_q  <= `SAP_RST_MASTER;
            long_q    <= `SAP_RST_LONG_SYNC;
            opt_q     <= `SAP_RST_OPT_FRAME;
            tx_slot_q <= `SAP_RST_TX_SLOT;
            rx_slot_q <= `SAP_RST_RX_SLOT;
            div_q     <= `SAP_RST_DIV_SEL;
        end else if (cfg_load) begin
            master_q  <= cfg_master;
            long_q    <= cfg_long_sync;
            opt_q     <= cfg_opt_frame;
            tx_slot_q <= cfg_tx_slot;
            rx_slot_q <= cfg_rx_slot;
            // Reserved divider code falls back to 1
            div_q     <= (cfg_div_sel == 2'b11) ? `SAP_DIV_BY_1 : cfg_div_sel;
        end
    end

    wire long_eff = master_q | long_q;
    wire opt_eff  = ~master_q & long_q & opt_q;
    // optimised frame carries data in slot two
    wire tx_slot_eff = opt_eff | tx_slot_q;
    wire rx_slot_eff = opt_eff | rx_slot_q;
    wire [4:0] slot2_start = opt_eff ? `SAP_SLOT2_START_OPT : `SAP_SLOT2_START;
    wire [4:0] tx_start    = tx_slot_eff ? slot2_start : `SAP_SLOT1_START;
    wire [4:0] rx_start    = rx_slot_eff ? slot2_start : `SAP_SLOT1_START;

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    wire [2:0] pins_s;
    pin_sync #(
        .W          (3)
    ) u_pin_sync (
        .clk        (clk),
        .rst        (rst),
        .pin_async  ({serial_in_line, frame_sync_in, bit_clk_in}),
        .pin_synced (pins_s)
    );
    wire bclk_s  = pins_s[0];
    wire frame_sync_s = pins_s[1];
    wire sdi_s   = pins_s[2];

    reg bclk_d_q;
    always @(posedge clk) begin
        if (rst) begin
            bclk_d_q <= 1'b0;
        end else begin
            bclk_d_q <= bclk_s;
        end
    end

    // ************************************************************
    // Master bit clock generator
    // ************************************************************
    // half bit period is 4 x divider clk cycles, so 256 x divider per frame
    wire [4:0] half_lim = `SAP_HALF_BIT_BASE << div_q;
    reg  [4:0] half_cnt_q;
    reg        bclk_gen_q;
    // Compare with >= so a divider lowered mid-count does not wrap the counter
    wire       half_tick = (half_cnt_q >= half_lim - 5'd1);

    always @(posedge clk) begin
        if (rst) begin
            half_cnt_q <= 5'd0;
            bclk_gen_q <= 1'b0;
        end else if (!master_q) begin
            half_cnt_q <= 5'd0;
            bclk_gen_q <= 1'b0;
        end else if (half_tick) begin
            half_cnt_q <= 5'd0;
            bclk_gen_q <= ~bclk_gen_q;
        end else begin
            half_cnt_q <= half_cnt_q + 5'd1;
        end
    end

    // ************************************************************
    // Bit clock edges
    // ************************************************************
    // one clock for both directions
    wire rise_ev = master_q ? (half_tick & ~bclk_gen_q) : (bclk_s & ~bclk_d_q);
    wire fall_ev = master_q ? (half_tick &  bclk_gen_q) : (~bclk_s & bclk_d_q);

    // ************************************************************
    // Frame position
    // ************************************************************
    reg  [4:0] bit_idx_q;
    reg        in_frame_q;
    reg        fs_fall_q;

    // short sync seen at fall, long sync at rise
    wire start_slave = long_eff ? (frame_sync_s & ~fs_fall_q) : fs_fall_q;
    wire start_now   = master_q ? (bit_idx_q == `SAP_LAST_BIT_IDX) : start_slave;
    wire       at_end    = (bit_idx_q == `SAP_LAST_BIT_IDX);
    reg  [4:0] idx_n;
    reg        frame_ok;

    // Index holds at 31 until the next sync and the frame closes there,
    // so missing syncs neither wrap nor repeat the last slot bit
    always @* begin
        idx_n    = bit_idx_q;
        frame_ok = 1'b0;
        if (start_now) begin
            idx_n    = 5'd0;
            frame_ok = 1'b1;
        end else if (!at_end) begin
            idx_n    = bit_idx_q + 5'd1;
            frame_ok = in_frame_q;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            bit_idx_q  <= `SAP_LAST_BIT_IDX;
            in_frame_q <= 1'b0;
        end else if (rise_ev) begin
            bit_idx_q  <= idx_n;
            in_frame_q <= frame_ok;
        end
    end

    always @(posedge clk) begin
        if (rst) begin
            fs_fall_q <= 1'b0;
        end else if (fall_ev) begin
            fs_fall_q <= master_q ? 1'b0 : frame_sync_s;
        end
    end

    // ************************************************************
    // Transmit path
    // ************************************************************
    wire [4:0] tx_off  = idx_n - tx_start;
    wire       tx_in   = frame_ok & (idx_n >= tx_start) & (tx_off < `SAP_SLOT_LEN);
    reg  [SAMPLE_W-1:0] tx_sh_q;

    always @(posedge clk) begin
        if (rst) begin
            tx_sh_q         <= {SAMPLE_W{1'b0}};
            serial_out_line <= 1'b0;
            adc_taken       <= 1'b0;
        end else begin
            adc_taken <= 1'b0;
            if (rise_ev) begin
                if (tx_in && tx_off == 5'd0) begin
                    serial_out_line <= adc_sample[SAMPLE_W-1];
                    tx_sh_q         <= {adc_sample[SAMPLE_W-2:0], 1'b0};
                    adc_taken       <= 1'b1;
                end else if (tx_in) begin
                    serial_out_line <= tx_sh_q[SAMPLE_W-1];
                    tx_sh_q         <= {tx_sh_q[SAMPLE_W-2:0], 1'b0};
                end else begin
                    serial_out_line <= 1'b0;
                end
            end
        end
    end

    // ************************************************************
    // Receive path
    // ************************************************************
    wire [4:0] rx_off = bit_idx_q - rx_start;
    wire       rx_in  = in_frame_q & (bit_idx_q >= rx_start) & (rx_off < `SAP_SLOT_LEN);
    reg  [SAMPLE_W-1:0] rx_sh_q;

    always @(posedge clk) begin
        if (rst) begin
            rx_sh_q    <= {SAMPLE_W{1'b0}};
            dac_sample <= {SAMPLE_W{1'b0}};
            dac_valid  <= 1'b0;
        end else begin
            dac_valid <= 1'b0;
            if (fall_ev && rx_in) begin
                rx_sh_q <= {rx_sh_q[SAMPLE_W-2:0], sdi_s};
                if (rx_off == `SAP_LAST_SLOT_OFF) begin
                    dac_sample <= {rx_sh_q[SAMPLE_W-2:0], sdi_s};
                    dac_valid  <= 1'b1;
                end
            end
        end
    end

    // ************************************************************
    // Pin drivers
    // ************************************************************
    always @(posedge clk) begin
        if (rst) begin
            bit_clk_out       <= 1'b0;
            bit_clk_oe        <= 1'b0;
            frame_sync_out    <= 1'b0;
            frame_sync_oe     <= 1'b0;
        end else begin
            bit_clk_out    <= master_q & (rise_ev ? 1'b1 : fall_ev ? 1'b0 : bit_clk_out);
            bit_clk_oe     <= master_q;
            frame_sync_oe  <= master_q;
            if (!master_q) begin
                frame_sync_out <= 1'b0;
            end else if (rise_ev) begin
                frame_sync_out <= (idx_n < `SAP_SLOT_LEN);
            end
        end
    end

    // ************************************************************
    // Status
    // ************************************************************
    always @(posedge clk) begin
        if (rst) begin
            frame_start       <= 1'b0;
            master_active     <= 1'b0;
            long_sync_format  <= 1'b0;
            short_sync_format <= 1'b1;
        end else begin
            frame_start       <= rise_ev & start_now;
            master_active     <= master_q;
            long_sync_format  <= long_eff;
            short_sync_format <= ~long_eff;
        end
    end

endmodule // codec_serial_audio_port

`default_nettype wire

// ---- design/codec_serial_audio_port_defines.vh ----
// Constants of the serial audio port: frame layout, clock ratios, reset values
`ifndef CODEC_SERIAL_AUDIO_PORT_DEFINES_VH
`define CODEC_SERIAL_AUDIO_PORT_DEFINES_VH

// ************************************************************
// Frame layout
// ************************************************************
`define SAP_SAMPLE_W          16
`define SAP_SLOT_LEN          5'd16
`define SAP_LAST_SLOT_OFF     5'd15
`define SAP_SLOT1_START       5'd0
`define SAP_SLOT2_START       5'd16
`define SAP_SLOT2_START_OPT   5'd1
`define SAP_LAST_BIT_IDX      5'd31
`define SAP_FRAME_BITS        32
`define SAP_OPT_FRAME_BITS    17

// ************************************************************
// Clock ratios (master clock = clk)
// ************************************************************
`define SAP_CLK_PER_FRAME     256
// Half bit period in clk cycles at divider 1: 256 / 32 / 2
`define SAP_HALF_BIT_BASE     5'd4
`define SAP_DIV_BY_1          2'b00
`define SAP_DIV_BY_2          2'b01
`define SAP_DIV_BY_4          2'b10

// ************************************************************
// Reset values of the configuration
// ************************************************************
`define SAP_RST_MASTER        1'b0
`define SAP_RST_LONG_SYNC     1'b0
`define SAP_RST_OPT_FRAME     1'b0
`define SAP_RST_TX_SLOT       1'b0
`define SAP_RST_RX_SLOT       1'b0
`define SAP_RST_DIV_SEL       2'b00

`endif

// ---- design/pin_sync.v ----
// Two-flop synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ns
`default_nettype none

module pin_sync #(
    parameter W = 3
) (
    input  wire         clk,
    input  wire         rst,
    input  wire [W-1:0] pin_async,
    output wire [W-1:0] pin_synced
);

    // ************************************************************
    // One synchroniser per pin
    // ************************************************************
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta_q;
            reg stable_q;
            always @(posedge clk) begin
                if (rst) begin
                    meta_q   <= 1'b0;
                    stable_q <= 1'b0;
                end else begin
                    meta_q   <= pin_async[i];
                    stable_q <= meta_q;
                end
            end
            assign pin_synced[i] = stable_q;
        end
    endgenerate

endmodule // pin_sync

`default_nettype wire

// ---- tb/codec_serial_audio_port_assertions.sv ----
// Port-level property checker for the serial audio port
`timescale 1ns/1ns
`default_nettype none
module codec_serial_audio_port_assertions (
    input wire logic clk,
    input wire logic rst,
    input wire logic cfg_load,
    input wire logic cfg_master,
    input wire logic bit_clk_out,
    input wire logic bit_clk_oe,
    input wire logic frame_sync_out,
    input wire logic frame_sync_oe,
    input wire logic adc_taken,
    input wire logic dac_valid,
    input wire logic frame_start,
    input wire logic master_active,
    input wire logic long_sync_format,
    input wire logic short_sync_format
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ****************
    // Mode relations
    // ****************
    a_format_pair: assert property (short_sync_format != long_sync_format)
        else $error("format flags agree");
    a_master_drives: assert property (master_active |-> bit_clk_oe && frame_sync_oe)
        else $error("master without pin drive");
    a_master_long: assert property (master_active |-> long_sync_format)
        else $error("master not in long format");
    a_slave_quiet: assert property (!master_active |-> !bit_clk_oe && !frame_sync_oe)
        else $error("slave drives clock pins");
    a_cfg_master: assert property (cfg_load && cfg_master |-> ##2 master_active)
        else $error("master load not taken");
    a_cfg_slave: assert property (cfg_load && !cfg_master |-> ##2 !master_active)
        else $error("slave load not taken");
    a_reset_slave: assert property ($fell(rst) |-> short_sync_format && !master_active)
        else $error("reset state not slave short");
    // ****************
    // Framing
    // ****************
    // Sync must open on a bit clock rise, never mid-period
    a_sync_edge: assert property ($rose(frame_sync_out) |-> $rose(bit_clk_out))
        else $error("sync rise off the bit clock rise");
    a_frame_pulse: assert property (frame_start |=> !frame_start)
        else $error("frame start wider than one cycle");
    a_dac_pulse: assert property (dac_valid |=> !dac_valid)
        else $error("receive strobe wider than one cycle");
    a_adc_pulse: assert property (adc_taken |=> !adc_taken)
        else $error("load strobe wider than one cycle");
endmodule // codec_serial_audio_port_assertions
`default_nettype wire

// ---- tb/dsp_port_model.sv ----
// Behavioural DSP serial port that clocks the codec in slave operation
`timescale 1ns/1ns
`default_nettype none
module dsp_port_model #(
    parameter int HALF = 8
) (
    input  wire logic clk,
    output logic      bclk,
    output logic      sync,
    output logic      dtx,
    input  wire logic drx
);
    logic [15:0] rx_word;
    initial begin
        bclk = 1'b0;
        sync = 1'b0;
        dtx = 1'b0;
        rx_word = 16'h0;
    end
    // ****************
    // Frame sequence
    // ****************
    // Clock stands still between sequences; a lead period carries the first short sync
    task automatic frames(input logic lng, input int np, k, ts, rs, input logic [15:0] tx);
        int g;
        int q;
        for (g = -1; g < k * np; g++) begin
            q = (g < 0) ? np - 1 : g % np;
            @(posedge clk);
            // one bit per period, period locked to clk
            bclk <= 1'b1;
            // period count per frame, sync placement
            sync <= lng ? (g >= 0 && q < 8) : (q == np - 1 && g < k * np - 1);
            // data changes at rise, inverted when idle
            dtx <= (q >= ts && q < ts + 16) ? tx[15 - (q - ts)] : ~dtx;
            repeat (HALF) @(posedge clk);
            bclk <= 1'b0;
            if (q >= rs && q < rs + 16) begin
                rx_word[15 - (q - rs)] = drx;
            end
            repeat (HALF - 1) @(posedge clk);
        end
        @(posedge clk);
        sync <= 1'b0;
        dtx <= ~dtx;
    endtask
endmodule // dsp_port_model
`default_nettype wire

// ---- tb/tb_codec_serial_audio_port.sv ----
// Self-checking bench for the serial audio port
`timescale 1ns/1ns
`default_nettype none
module tb_codec_serial_audio_port;
    logic        clk, rst, cfg_load, cfg_master, cfg_long_sync, cfg_opt_frame;
    logic        cfg_tx_slot, cfg_rx_slot, bclk, sync, dtx, bit_clk_out, bit_clk_oe;
    logic        frame_sync_out, frame_sync_oe, serial_out_line, adc_taken, dac_valid;
    logic        frame_start, master_active, long_sync_format, short_sync_format;
    logic [1:0]  cfg_div_sel;
    logic [15:0] adc_sample, dac_sample;
    logic        fs_q, bc_q;
    int          failures, checked, cyc, n_fs, n_dv, n_at, fs_t, bc_t, fs_per, bc_per;
    localparam int LIMIT = 40000;

    codec_serial_audio_port i_dut (.clk(clk), .rst(rst), .cfg_load(cfg_load),
        .cfg_master(cfg_master), .cfg_long_sync(cfg_long_sync), .cfg_opt_frame(cfg_opt_frame),
        .cfg_tx_slot(cfg_tx_slot), .cfg_rx_slot(cfg_rx_slot), .cfg_div_sel(cfg_div_sel),
        .bit_clk_in(bclk), .bit_clk_out(bit_clk_out), .bit_clk_oe(bit_clk_oe),
        .frame_sync_in(sync), .frame_sync_out(frame_sync_out), .frame_sync_oe(frame_sync_oe),
        .serial_in_line(dtx), .serial_out_line(serial_out_line), .adc_sample(adc_sample),
        .adc_taken(adc_taken), .dac_sample(dac_sample), .dac_valid(dac_valid),
        .frame_start(frame_start), .master_active(master_active),
        .long_sync_format(long_sync_format), .short_sync_format(short_sync_format));
    dsp_port_model i_dsp (.clk(clk), .bclk(bclk), .sync(sync), .dtx(dtx),
        .drx(serial_out_line));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ****************
    // Monitors and timeout
    // ****************
    always @(posedge clk) begin
        cyc++;
        n_fs += (frame_start === 1'b1);
        n_dv += (dac_valid === 1'b1);
        n_at += (adc_taken === 1'b1);
        if (frame_sync_out === 1'b1 && fs_q === 1'b0) begin
            fs_per = cyc - fs_t;
            fs_t = cyc;
        end
        if (bit_clk_out === 1'b1 && bc_q === 1'b0) begin
            bc_per = cyc - bc_t;
            bc_t = cyc;
        end
        fs_q = frame_sync_out;
        bc_q = bit_clk_out;
        if (cyc == LIMIT) begin
            failures++;
            wrap_up;
        end
    end
    // ****************
    // Shared tasks
    // ****************
    task automatic chk(input string what, input logic [31:0] exp, got);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, got);
        end
    endtask
    task automatic set_cfg(input logic m, l, o, t, r, input logic [1:0] d);
        @(posedge clk);
        cfg_load <= 1'b1;
        cfg_master <= m;
        cfg_long_sync <= l;
        cfg_opt_frame <= o;
        cfg_tx_slot <= t;
        cfg_rx_slot <= r;
        cfg_div_sel <= d;
        @(posedge clk);
        cfg_load <= 1'b0;
        @(posedge clk);
    endtask
    task automatic t_reset;
        chk("short_sync_format", 32'h1, short_sync_format);
        chk("master_active", 32'h0, master_active);
        chk("bit_clk_oe", 32'h0, bit_clk_oe);
        $display("reset test done");
    endtask
    // Three frames each way; mt and mr are the model's slot start periods
    task automatic t_slave(input logic l, o, t, r, input int np, mt, mr, input logic [15:0] w, a);
        set_cfg(1'b0, l, o, t, r, 2'h0);
        adc_sample <= a;
        n_fs = 0;
        n_dv = 0;
        n_at = 0;
        i_dsp.frames(l, np, 3, mt, mr, w);
        // Lets the final receive strobe clear the input synchroniser
        repeat (8) @(posedge clk);
        chk("dac_sample", w, dac_sample);
        chk("serial word", a, i_dsp.rx_word);
        chk("frame starts", 32'h3, n_fs);
        chk("dac updates", 32'h3, n_dv);
        chk("adc loads", 32'h3, n_at);
        $display("slave test done");
    endtask
    // Opt bit set too: master must ignore it
    task automatic t_master(input logic [1:0] d, input int f);
        set_cfg(1'b1, 1'b0, 1'b1, 1'b0, 1'b0, d);
        repeat (600 * f) @(posedge clk);
        chk("frame period", 256 * f, fs_per);
        chk("bit period", 8 * f, bc_per);
        chk("long_sync_format", 32'h1, long_sync_format);
        $display("master test done");
    endtask
    task wrap_up;
        $display("checks %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****************
    // Main sequence
    // ****************
    initial begin
        {rst, cfg_load, cfg_master, cfg_long_sync, cfg_opt_frame} = 5'h10;
        {cfg_tx_slot, cfg_rx_slot, cfg_div_sel, fs_q, bc_q} = 6'h0;
        adc_sample = 16'h0;
        {failures, checked, cyc, n_fs, n_dv, n_at, fs_t, bc_t, fs_per, bc_per} = '0;
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        t_reset;
        t_slave(0, 0, 0, 0, 32, 0, 0, 16'h8001, 16'h7ffe);
        t_slave(0, 0, 1, 0, 32, 0, 16, 16'h5a3c, 16'hc3a5);
        t_slave(1, 0, 0, 1, 32, 16, 0, 16'h1234, 16'hfedc);
        t_slave(1, 1, 0, 0, 17, 1, 1, 16'hbeef, 16'h0f0f);
        t_slave(0, 1, 1, 1, 32, 16, 16, 16'h4321, 16'h8000);
        for (int d = 0; d < 4; d++) begin
            t_master(d[1:0], d == 2 ? 4 : d == 1 ? 2 : 1);
        end
        wrap_up;
    end
endmodule // tb_codec_serial_audio_port

bind codec_serial_audio_port codec_serial_audio_port_assertions i_chk (.clk(clk), .rst(rst),
    .cfg_load(cfg_load), .cfg_master(cfg_master), .bit_clk_out(bit_clk_out),
    .bit_clk_oe(bit_clk_oe), .frame_sync_out(frame_sync_out), .frame_sync_oe(frame_sync_oe),
    .adc_taken(adc_taken), .dac_valid(dac_valid), .frame_start(frame_start),
    .master_active(master_active), .long_sync_format(long_sync_format),
    .short_sync_format(short_sync_format));
`default_nettype wire
